/* File: include/drive_ctl_pkg.sv */
// constants, signal numbers and mapping checks for the drive control word decoder
package drive_ctl_pkg;

   localparam int CW_W   = 16;
   localparam int NUM_W  = 16;
   localparam int DATA_W = 32;
   localparam int SP_SLOTS  = 10;
   localparam int ACT_SLOTS = 14;

   // control word bit positions
   localparam int CW_ON    = 0;
   localparam int CW_COAST = 1;
   localparam int CW_QSTOP = 2;
   localparam int CW_ENOP  = 3;
   localparam int CW_RAMP  = 5;
   localparam int CW_SETP  = 6;
   localparam int CW_ACK   = 7;
   localparam int CW_PLC   = 10;
   localparam int CW_TRQ   = 11;
   localparam int CW_DIR   = 12;
   localparam int CW_POS   = 13;
   localparam logic [15:0] CW_UNUSED_MASK = 16'hC310;
   localparam logic [15:0] CW_RESET       = 16'h0000;

   // mapping signal numbers
   localparam logic [15:0] SIG_UNUSED     = 16'h270F;
   localparam logic [15:0] SIG_SPEED_SP   = 16'h0005;
   localparam logic [15:0] SIG_TORQUE_SP  = 16'h0064;
   localparam logic [15:0] SIG_SPEED_ACT  = 16'h0006;
   localparam logic [15:0] SIG_TORQUE_ACT = 16'h0065;
   localparam logic [15:0] SIG_PARAM_LO   = 16'h3000;
   localparam logic [15:0] SIG_PARAM_HI   = 16'h35DB;
   localparam logic [15:0] SIG_MON_LO     = 16'h4000;
   localparam logic [15:0] SIG_MON_HI     = 16'h4063;
   localparam logic [15:0] SIG_CTRL_A     = 16'h5008;
   localparam logic [15:0] SIG_CTRL_B     = 16'h5009;
   localparam logic [15:0] SIG_CTRLX_LO   = 16'h51F5;
   localparam logic [15:0] SIG_CTRLX_HI   = 16'h51FE;
   localparam logic [15:0] SIG_CTRLX_END  = 16'h5200;

   // 16384 in the speed setpoint equals the maximum frequency
   localparam int SP_REF_SHIFT = 14;

   // fault acknowledge hold time
   localparam int ACK_MS   = 20;
   localparam int CLK_NS   = 10;
   localparam int ACK_CYC  = ACK_MS * 1000000 / CLK_NS;

   function automatic logic sp_num_ok(input logic [15:0] n);
      return (n == SIG_SPEED_SP) || (n == SIG_TORQUE_SP) ||
             (n >= SIG_PARAM_LO && n <= SIG_PARAM_HI) ||
             (n == SIG_CTRL_A) || (n == SIG_CTRL_B);
   endfunction

   function automatic logic act_num_ok(input logic [15:0] n);
      return (n == SIG_SPEED_ACT) || (n == SIG_TORQUE_ACT) ||
             (n >= SIG_PARAM_LO && n <= SIG_PARAM_HI) ||
             (n >= SIG_MON_LO && n <= SIG_MON_HI) ||
             (n == SIG_CTRL_A) || (n == SIG_CTRL_B) ||
             (n >= SIG_CTRLX_LO && n <= SIG_CTRLX_HI) || (n == SIG_CTRLX_END);
   endfunction

endpackage

/* File: include/actual_src_if.sv */
// actual values shared by the outgoing mapping slots
`timescale 1ns/1ps
interface actual_src_if;
   logic signed [15:0] speed_act;
   logic signed [15:0] torque_act;
   modport src (output speed_act, output torque_act);
   modport snk (input speed_act, input torque_act);
endinterface

/* File: verilog/actual_slot.sv */
// one slot of the outgoing actual-value telegram
`timescale 1ns/1ps
module actual_slot (
   input  wire logic        mclk_i,   // clock
   input  wire logic        nrst_i,   // sync reset, low
   input  wire logic        load_i,   // telegram strobe
   input  wire logic [15:0] map_i,    // signal number
   input  wire logic [31:0] ext_i,    // value for other numbers
   actual_src_if.snk        src,      // speed and torque
   output logic      [31:0] data_o    // slot contents
);
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         data_o <= 32'h0000_0000;
      end else if (load_i) begin
         if (!drive_ctl_pkg::act_num_ok(map_i)) begin
            data_o <= 32'h0000_0000;
         end else if (map_i == drive_ctl_pkg::SIG_SPEED_ACT) begin
            data_o <= 32'(src.speed_act);
         end else if (map_i == drive_ctl_pkg::SIG_TORQUE_ACT) begin
            data_o <= 32'(src.torque_act);
         end else begin
            data_o <= ext_i;
         end
      end
   end
endmodule

/* File: verilog/fault_ack_timer.sv */
// fault acknowledge: edge detect plus hold timer
`timescale 1ns/1ps
module fault_ack_timer #(
   parameter int unsigned HOLD_CYC = drive_ctl_pkg::ACK_CYC
) (
   input  wire logic mclk_i,          // clock
   input  wire logic nrst_i,          // sync reset, low
   input  wire logic ack_i,           // decoded acknowledge level
   input  wire logic fault_active_i,  // fault present
   input  wire logic fault_severe_i,  // fault needs power or drive reset
   output logic      buf_clear_o,     // pulse: clear fault buffer
   output logic      prot_reset_o     // pulse: reset protective function
);
   logic        ack_q;
   logic        armed;
   logic [31:0] cnt;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_i;
      end
   end

   // only a fresh rising edge arms; a level left high never re-fires
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         armed <= 1'b0;
         cnt   <= 32'h0000_0000;
      end else if (!ack_i) begin
         armed <= 1'b0;
         cnt   <= 32'h0000_0000;
      end else if (!ack_q) begin
         armed <= 1'b1;
         cnt   <= 32'h0000_0001;
      end else if (armed && cnt >= HOLD_CYC) begin
         armed <= 1'b0;
      end else if (armed) begin
         cnt <= cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         buf_clear_o  <= 1'b0;
         prot_reset_o <= 1'b0;
      end else begin
         buf_clear_o  <= ack_i && ack_q && armed && cnt >= HOLD_CYC;
         prot_reset_o <= ack_i && ack_q && armed && cnt >= HOLD_CYC
                         && fault_active_i && !fault_severe_i;
      end
   end
endmodule

/* File: verilog/drive_control_word_decoder.sv */
// drive control word decoder with setpoint and actual-value slot mapping
//
// Overview of operation
// - duplicate setpoint signal numbers: lowest slot wins, others count as unused
// - setpoint slot with unknown number or 9999 writes nothing
// - actual slot with unknown number or 9999 returns zero
// - bit 0 on/off, bit 1 shutoff release, bit 3 operation enable
// - bit 2 low means emergency stop, high releases it
// - bit 5 low halts the ramp, only during speed control
// - ramp halt ignored with start off or during automatic restart
// - early revision: halt freezes set frequency, only with setpoint-word speed
// - late revision: set frequency untouched, halt applies to any speed source
// - bit 6 low forces set frequency to zero
// - bit 7 rising, held 20 ms, clears fault buffer and resets protection
// - severe faults are not reset by acknowledge
// - bit 10 low disables the whole control word
// - bit 11 low forces torque command to zero
// - bit 12 inverts the meaning of the setpoint sign
// - bit 13 starts positioning only in position control and enabled state
// - setpoint 16384 equals the maximum output frequency
`timescale 1ns/1ps
module drive_control_word_decoder #(
   parameter int unsigned ACK_HOLD_CYC = drive_ctl_pkg::ACK_CYC
) (
   input  wire logic         mclk_i,                     // 100 MHz clock
   input  wire logic         nrst_i,                     // sync reset, low
   input  wire logic         tel_valid_i,                // new setpoint telegram
   input  wire logic [15:0]  drive_control_word_i,       // control word
   input  wire logic [159:0] sp_map_i,                   // setpoint slot numbers
   input  wire logic [319:0] sp_data_i,                  // setpoint slot data
   input  wire logic [223:0] act_map_i,                  // actual slot numbers
   input  wire logic [447:0] act_ext_i,                  // values for other numbers
   input  wire logic [15:0]  speed_actual_word_i,        // present speed
   input  wire logic [15:0]  actual_torque_i,            // present torque
   input  wire logic [15:0]  max_freq_i,                 // maximum frequency
   input  wire logic         speed_control_i,            // drive in speed control
   input  wire logic         speed_from_word_i,          // speed given by setpoint word
   input  wire logic         position_control_i,         // drive in position control
   input  wire logic         operation_enabled_state_i,  // drive state machine enabled
   input  wire logic         auto_restart_i,             // restart after power dip
   input  wire logic         hw_rev_late_i,              // strap: later hardware
   input  wire logic         fault_active_i,             // fault present
   input  wire logic         fault_severe_i,             // fault not acknowledgeable
   output logic              plc_control_o,              // control word in force
   output logic              run_cmd_o,                  // on command
   output logic              shutoff_release_o,          // output shutoff released
   output logic              quick_stop_o,               // emergency stop active
   output logic              operation_enable_o,         // operation enabled
   output logic              ramp_hold_o,                // hold acceleration
   output logic signed [31:0] set_freq_o,                // set frequency
   output logic              reverse_o,                  // reverse direction
   output logic       [15:0] torque_cmd_o,               // torque command
   output logic              pos_start_o,                // positioning start
   output logic              fault_buffer_clear_o,       // pulse: buffer cleared
   output logic              protective_reset_o,         // pulse: protection reset
   output logic        [9:0] sp_slot_wr_o,               // pulse: slot data written
   output logic      [447:0] act_data_o                  // actual telegram
);
   logic [15:0]        cw;
   logic               rev_meta;
   logic               rev_late;
   logic signed [15:0] speed_sp;
   logic               spd_hit;
   logic [15:0]        spd_val;
   logic               trq_hit;
   logic [15:0]        trq_val;
   logic [9:0]         next_wr;
   logic               plc_now;
   logic               intr_now;
   logic signed [15:0] next_sp;

   actual_src_if src_bus ();

   assign src_bus.speed_act  = speed_actual_word_i;
   assign src_bus.torque_act = actual_torque_i;

   function automatic logic signed [31:0] scale(input logic signed [15:0] v,
                                                input logic        [15:0] fmax);
      logic signed [32:0] prod;
      prod = v * $signed({1'b0, fmax});
      return 32'(prod >>> drive_ctl_pkg::SP_REF_SHIFT);
   endfunction

   // strap arrives from a pin
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         rev_meta <= 1'b0;
         rev_late <= 1'b0;
      end else begin
         rev_meta <= hw_rev_late_i;
         rev_late <= rev_meta;
      end
   end

   // setpoint slot resolution
   always_comb begin
      logic [15:0] num;
      logic        dup;
      num     = 16'h0000;
      dup     = 1'b0;
      next_wr = '0;
      spd_hit = 1'b0;
      spd_val = 16'h0000;
      trq_hit = 1'b0;
      trq_val = 16'h0000;
      for (int i = 0; i < drive_ctl_pkg::SP_SLOTS; i++) begin
         num = sp_map_i[i*drive_ctl_pkg::NUM_W +: drive_ctl_pkg::NUM_W];
         dup = 1'b0;
         for (int j = 0; j < i; j++) begin
            if (sp_map_i[j*drive_ctl_pkg::NUM_W +: drive_ctl_pkg::NUM_W] == num) begin
               dup = 1'b1;
            end
         end
         if (drive_ctl_pkg::sp_num_ok(num) && !dup) begin
            next_wr[i] = 1'b1;
            if (num == drive_ctl_pkg::SIG_SPEED_SP) begin
               spd_hit = 1'b1;
               spd_val = sp_data_i[i*drive_ctl_pkg::DATA_W +: 16];
            end
            if (num == drive_ctl_pkg::SIG_TORQUE_SP) begin
               trq_hit = 1'b1;
               trq_val = sp_data_i[i*drive_ctl_pkg::DATA_W +: 16];
            end
         end
      end
   end

   assign plc_now  = drive_control_word_i[drive_ctl_pkg::CW_PLC];
   assign next_sp  = spd_hit ? $signed(spd_val) : speed_sp;
   // early-revision halt: decided at the telegram from the incoming word
   assign intr_now = plc_now && !drive_control_word_i[drive_ctl_pkg::CW_RAMP]
                     && drive_control_word_i[drive_ctl_pkg::CW_ON]
                     && speed_control_i && !auto_restart_i;

   // latch the word; a disabled word is stored as all zero
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         cw       <= drive_ctl_pkg::CW_RESET;
         speed_sp <= 16'h0000;
      end else if (tel_valid_i) begin
         cw       <= plc_now ? drive_control_word_i : drive_ctl_pkg::CW_RESET;
         speed_sp <= next_sp;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         sp_slot_wr_o <= '0;
      end else begin
         sp_slot_wr_o <= tel_valid_i ? next_wr : 10'h000;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         plc_control_o      <= 1'b0;
         run_cmd_o          <= 1'b0;
         shutoff_release_o  <= 1'b0;
         quick_stop_o       <= 1'b0;
         operation_enable_o <= 1'b0;
      end else if (tel_valid_i) begin
         plc_control_o      <= plc_now;
         run_cmd_o          <= plc_now && drive_control_word_i[drive_ctl_pkg::CW_ON];
         shutoff_release_o  <= plc_now && drive_control_word_i[drive_ctl_pkg::CW_COAST];
         quick_stop_o       <= plc_now && !drive_control_word_i[drive_ctl_pkg::CW_QSTOP];
         operation_enable_o <= plc_now && drive_control_word_i[drive_ctl_pkg::CW_ENOP];
      end
   end

   // set frequency, torque and direction
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         set_freq_o   <= 32'sh0000_0000;
         torque_cmd_o <= 16'h0000;
         reverse_o    <= 1'b0;
      end else if (tel_valid_i) begin
         if (!plc_now || !drive_control_word_i[drive_ctl_pkg::CW_SETP]) begin
            set_freq_o <= 32'sh0000_0000;
         end else if (intr_now && !rev_late && speed_from_word_i) begin
            set_freq_o <= scale($signed(speed_actual_word_i), max_freq_i);
         end else begin
            set_freq_o <= scale(next_sp, max_freq_i);
         end
         if (plc_now && drive_control_word_i[drive_ctl_pkg::CW_TRQ]) begin
            torque_cmd_o <= trq_hit ? trq_val : torque_cmd_o;
         end else begin
            torque_cmd_o <= 16'h0000;
         end
         if (drive_control_word_i[drive_ctl_pkg::CW_DIR] && plc_now) begin
            reverse_o <= next_sp > 16'sh0000;
         end else begin
            reverse_o <= next_sp < 16'sh0000;
         end
      end
   end

   // halt and start follow live drive conditions every cycle
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         ramp_hold_o <= 1'b0;
         pos_start_o <= 1'b0;
      end else begin
         ramp_hold_o <= rev_late && !cw[drive_ctl_pkg::CW_RAMP] && cw[drive_ctl_pkg::CW_PLC]
                        && cw[drive_ctl_pkg::CW_ON] && speed_control_i
                        && !auto_restart_i;
         pos_start_o <= cw[drive_ctl_pkg::CW_POS] && position_control_i
                        && operation_enabled_state_i;
      end
   end

   fault_ack_timer #(
      .HOLD_CYC (ACK_HOLD_CYC)
   ) u_ack (
      .mclk_i         (mclk_i),
      .nrst_i         (nrst_i),
      .ack_i          (cw[drive_ctl_pkg::CW_ACK]),
      .fault_active_i (fault_active_i),
      .fault_severe_i (fault_severe_i),
      .buf_clear_o    (fault_buffer_clear_o),
      .prot_reset_o   (protective_reset_o)
   );

   for (genvar k = 0; k < drive_ctl_pkg::ACT_SLOTS; k++) begin : g_act
      actual_slot u_slot (
         .mclk_i (mclk_i),
         .nrst_i (nrst_i),
         .load_i (tel_valid_i),
         .map_i  (act_map_i[k*drive_ctl_pkg::NUM_W +: drive_ctl_pkg::NUM_W]),
         .ext_i  (act_ext_i[k*drive_ctl_pkg::DATA_W +: drive_ctl_pkg::DATA_W]),
         .src    (src_bus.snk),
         .data_o (act_data_o[k*drive_ctl_pkg::DATA_W +: drive_ctl_pkg::DATA_W])
      );
   end

   // helper: cycles the acknowledge level has been held
   logic [31:0] ack_held;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i || !cw[drive_ctl_pkg::CW_ACK]) begin
         ack_held <= 32'h0000_0000;
      end else if (ack_held != 32'hFFFF_FFFF) begin
         ack_held <= ack_held + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   AST_DUP_SLOT: assert property (
      tel_valid_i && sp_map_i[15:0] == sp_map_i[31:16] |=> !sp_slot_wr_o[1])
      else $error("duplicate setpoint number written twice");

   AST_BAD_SLOT: assert property (
      tel_valid_i && !drive_ctl_pkg::sp_num_ok(sp_map_i[47:32]) |=> !sp_slot_wr_o[2])
      else $error("invalid setpoint slot written");

   AST_ACT_ZERO: assert property (
      tel_valid_i && !drive_ctl_pkg::act_num_ok(act_map_i[47:32]) |=> act_data_o[95:64] == 0)
      else $error("invalid actual slot not zero");

   AST_DECODE: assert property (
      tel_valid_i && drive_control_word_i[10] |=>
      run_cmd_o == $past(drive_control_word_i[0]) &&
      shutoff_release_o == $past(drive_control_word_i[1]) &&
      operation_enable_o == $past(drive_control_word_i[3]))
      else $error("on, coast or enable bit decoded wrong");

   AST_QSTOP: assert property (
      tel_valid_i && drive_control_word_i[10] |=> quick_stop_o != $past(drive_control_word_i[2]))
      else $error("emergency stop polarity wrong");

   AST_RAMP_GATE: assert property (
      ramp_hold_o |-> $past(!auto_restart_i) && $past(run_cmd_o) && $past(speed_control_i))
      else $error("ramp halt outside its conditions");

   AST_SETP_ZERO: assert property (
      tel_valid_i && !drive_control_word_i[6] |=> set_freq_o == 0)
      else $error("setpoint not forced to zero");

   AST_TRQ_ZERO: assert property (
      tel_valid_i && !drive_control_word_i[11] |=> torque_cmd_o == 0)
      else $error("torque command not forced to zero");

   AST_PLC_OFF: assert property (
      tel_valid_i && !drive_control_word_i[10] |=> !plc_control_o && !run_cmd_o && !quick_stop_o)
      else $error("disabled control word still acts");

   AST_POS: assert property (
      pos_start_o |-> $past(position_control_i) && $past(operation_enabled_state_i))
      else $error("positioning start outside allowed state");

   AST_ACK_HOLD: assert property (
      fault_buffer_clear_o |-> ack_held >= ACK_HOLD_CYC)
      else $error("fault buffer cleared too early");

   AST_SEVERE: assert property (
      protective_reset_o |-> fault_buffer_clear_o && $past(!fault_severe_i, 1))
      else $error("severe fault reset by acknowledge");

   AST_HOLD: assert property (
      !tel_valid_i |=> $stable(run_cmd_o) && $stable(set_freq_o))
      else $error("decoded command changed without telegram");

   COV_RUN: cover property (tel_valid_i && drive_control_word_i[10] ##1 run_cmd_o);
   COV_ACK: cover property (fault_buffer_clear_o);
   COV_DUP: cover property (tel_valid_i && sp_map_i[15:0] == sp_map_i[31:16]);
   COV_HALT: cover property (ramp_hold_o);
endmodule

/* File: test/plc_model.sv */
// network controller model sending setpoint telegrams
`timescale 1ns/1ps
module plc_model (
   input  wire logic        mclk_i,       // clock
   output logic             tel_valid_o,  // telegram strobe
   output logic      [15:0] word_o        // control word
);
   initial begin
      tel_valid_o = 1'b0;
      word_o      = 16'h0000;
   end
   // one telegram per call, launched just after an edge
   task automatic send(input logic [15:0] w);
      @(posedge mclk_i);
      #1;
      tel_valid_o = 1'b1;
      word_o      = w & 16'h3CEF;
      @(posedge mclk_i);
      #1;
      tel_valid_o = 1'b0;
      // word is only meaningful with the strobe, so scramble it
      word_o      = ~word_o & 16'h3CEF;
   endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the drive control word decoder
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [15:0] w; logic [15:0] sp; logic [15:0] tq; logic [5:0] f;
                   logic [31:0] fr;} row_t;
   logic          mclk_i, nrst_i, tel, late, spc, sfw, posc, opst, arst, flt, sev;
   logic [15:0]   word, spa, tqa, fmax;
   logic [159:0]  sp_map;
   logic [319:0]  sp_data;
   logic [223:0]  act_map;
   logic          plc, run, shut, qs, en, hold, rev, pos, bclr, prst;
   logic [31:0]   fr;
   logic [15:0]   trq;
   logic [9:0]    wr;
   logic [447:0]  act;
   int            error_cnt, n_tests, k;
   row_t          rows [6];
   plc_model plc_m (.mclk_i(mclk_i), .tel_valid_o(tel), .word_o(word));
   drive_control_word_decoder #(.ACK_HOLD_CYC(8)) dut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .tel_valid_i(tel), .drive_control_word_i(word),
      .sp_map_i(sp_map), .sp_data_i(sp_data), .act_map_i(act_map),
      .act_ext_i({14{32'h5A5A_0F0F}}), .speed_actual_word_i(spa),
      .actual_torque_i(tqa), .max_freq_i(fmax), .speed_control_i(spc),
      .speed_from_word_i(sfw), .position_control_i(posc), .operation_enabled_state_i(opst),
      .auto_restart_i(arst), .hw_rev_late_i(late), .fault_active_i(flt),
      .fault_severe_i(sev), .plc_control_o(plc), .run_cmd_o(run), .shutoff_release_o(shut),
      .quick_stop_o(qs), .operation_enable_o(en), .ramp_hold_o(hold), .set_freq_o(fr),
      .reverse_o(rev), .torque_cmd_o(trq), .pos_start_o(pos), .fault_buffer_clear_o(bclr),
      .protective_reset_o(prst), .sp_slot_wr_o(wr), .act_data_o(act));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset();
      nrst_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
   task automatic wait_ack(input logic exp_prst);
      for (k = 0; k < 40 && bclr !== 1'b1; k++) begin
         @(posedge mclk_i);
         #1;
      end
      chk("buf_clear", bclr, 1'b1);
      chk("prot_reset", prst, exp_prst);
   endtask
   initial begin
      error_cnt = 0;
      n_tests   = 0;
      {nrst_i, late, spc, sfw, posc, opst, arst, flt, sev} = '0;
      spa     = 16'h0321;
      tqa     = 16'h0042;
      fmax    = 16'h1388;
      sp_map  = {{8{16'h270F}}, 16'h0064, 16'h0005};
      sp_data = '0;
      act_map = {{9{16'h270F}}, 16'h1234, 16'h3000, 16'h270F, 16'h0065, 16'h0006};
      rows[0] = '{16'h0447, 16'h4000, 16'h0009, 6'b111000, 32'h0000_1388};
      rows[1] = '{16'h040E, 16'h4000, 16'h0009, 6'b101010, 32'h0000_0000};
      rows[2] = '{16'h0C41, 16'hE000, 16'h0032, 6'b110101, 32'hFFFF_F63C};
      rows[3] = '{16'h1C49, 16'hE000, 16'h004D, 6'b110110, 32'hFFFF_F63C};
      rows[4] = '{16'h1441, 16'h2000, 16'h0021, 6'b110101, 32'h0000_09C4};
      rows[5] = '{16'h004F, 16'h0064, 16'h0009, 6'b000000, 32'h0000_0000};
      do_reset();
      chk("reset_flags", {plc, run, shut, qs, en, rev, wr}, '0);
      chk("reset_freq", fr, '0);
      foreach (rows[i]) begin
         sp_data[15:0]  = rows[i].sp;
         sp_data[47:32] = rows[i].tq;
         plc_m.send(rows[i].w);
         chk("flags", {plc, run, shut, qs, en, rev}, rows[i].f);
         chk("set_freq", fr, rows[i].fr);
         chk("torque", trq, (rows[i].w[11] & rows[i].w[10]) ? rows[i].tq : '0);
         chk("dir", rev, rows[i].f[0]);
         chk("wr", wr, 10'h003);
      end
      chk("act0", act[15:0], 16'h0321);
      chk("act1", act[47:32], 16'h0042);
      chk("act2", act[95:64], '0);
      chk("act3", act[127:96], 32'h5A5A_0F0F);
      chk("act4", act[159:128], '0);
      // duplicate speed slot, unused and unknown numbers
      sp_map  = {{5{16'h270F}}, 16'h0064, 16'h1234, 16'h270F, 16'h0005, 16'h0005};
      sp_data = {{8{32'h0000_0000}}, 32'h0000_2000, 32'h0000_4000};
      plc_m.send(16'h0447);
      chk("dup_wr", wr, 10'h011);
      chk("dup_freq", fr, 32'h0000_1388);
      @(posedge mclk_i);
      #1;
      chk("wr_pulse", wr, '0);
      // positioning start needs position control and enabled state
      {posc, opst} = 2'b11;
      plc_m.send(16'h2408);
      @(posedge mclk_i);
      #1;
      chk("pos_on", pos, 1'b1);
      opst = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk("pos_off", pos, 1'b0);
      // acknowledge with an ordinary fault, then with a severe one
      flt = 1'b1;
      plc_m.send(16'h0480);
      wait_ack(1'b1);
      plc_m.send(16'h0400);
      sev = 1'b1;
      plc_m.send(16'h0480);
      wait_ack(1'b0);
      // early revision: halt loads the set frequency from the present speed
      {spc, sfw} = 2'b11;
      spa = 16'hFC00;
      tqa = 16'h0077;
      plc_m.send(16'h0441);
      chk("freeze", fr, 32'hFFFF_FEC7);
      chk("hold_early", hold, 1'b0);
      chk("act0_new", act[15:0], 16'hFC00);
      chk("act1_new", act[47:32], 16'h0077);
      // later revision strap: halt shows on ramp_hold_o
      late = 1'b1;
      spc  = 1'b1;
      do_reset();
      plc_m.send(16'h0401);
      @(posedge mclk_i);
      #1;
      chk("hold_on", hold, 1'b1);
      arst = 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
      chk("hold_restart", hold, 1'b0);
      arst = 1'b0;
      plc_m.send(16'h0421);
      @(posedge mclk_i);
      #1;
      chk("hold_off", hold, 1'b0);
      results();
   end
endmodule
